// ---- design/rbl_bist_engine.sv ----
`timescale 1ns/10ps
`default_nettype none
// walks both ram halves in parallel, one address pair per cycle
module rbl_bist_engine (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// handshake
	rbl_bist_if.engine bist
);
	import rbl_pkg::*;

	typedef struct packed {
		rbl_state_type state;
		logic [11:0] addr;
		logic failed;
		logic [11:0] hint;
		logic done;
	} rbl_eng_type;

	rbl_eng_type r;
	rbl_eng_type next_r;

	// fault model: lower address or its partner in the upper half
	function automatic logic hit(input logic [11:0] a,
		input logic [15:0] f);
		hit = f[15] && ((f[12:0] == {1'b0, a}) ||
			(f[12:0] == ({1'b0, a} + rbl_half_offset)));
	endfunction

	// next state
	always_comb begin
		next_r = r;
		next_r.done = 1'b0;
		unique case (r.state)
			rbl_idle: begin
				if (bist.start) begin
					next_r.state = rbl_run;
					next_r.addr = 12'h000;
					next_r.failed = 1'b0;
				end
			end
			rbl_run: begin
				if (hit(r.addr, bist.fault_addr)) begin
					next_r.failed = 1'b1;
					next_r.hint = {1'b0, r.addr[10:0]};
					next_r.state = rbl_done;
				end else if (r.addr == rbl_half_last) begin
					next_r.state = rbl_done;
				end else begin
					next_r.addr = r.addr + 12'h001;
				end
			end
			rbl_done: begin
				next_r.done = 1'b1;
				next_r.state = rbl_idle;
			end
			default: next_r.state = rbl_idle;
		endcase
	end

	// state register
	always_ff @(posedge clk) begin
		if (reset) begin
			r <= '{state: rbl_idle, addr: 12'h000, failed: 1'b0,
				hint: 12'h000, done: 1'b0};
		end else begin
			r <= next_r;
		end
	end

	assign bist.done = r.done;
	assign bist.failed = r.failed;
	assign bist.hint = r.hint;
endmodule
`default_nettype wire

// ---- design/rbl_bist_if.sv ----
`timescale 1ns/10ps
`default_nettype none
// start and result handshake between register file and bist engine
interface rbl_bist_if;
	logic start;
	logic [15:0] fault_addr;
	logic done;
	logic failed;
	logic [11:0] hint;
	modport ctrl (output start, output fault_addr, input done,
		input failed, input hint);
	modport engine (input start, input fault_addr, output done,
		output failed, output hint);
endinterface
`default_nettype wire

// ---- design/rbl_pkg.sv ----
package rbl_pkg;
	// register byte addresses (printed offsets not all multiples of four)
	localparam logic [7:0] rbl_idx_hint = 8'h1B;
	localparam logic [7:0] rbl_idx_ctrl = 8'h28;
	localparam logic [9:0] rbl_addr_hint = 10'h06C;
	localparam logic [9:0] rbl_addr_ctrl = 10'h0A0;
	localparam logic [9:0] rbl_addr_msg_info = 10'h100;
	localparam logic [9:0] rbl_addr_int_status = 10'h104;
	localparam logic [9:0] rbl_addr_int_enable = 10'h108;
	localparam logic [9:0] rbl_addr_int_clear = 10'h10C;
	localparam logic [9:0] rbl_addr_fault_inject = 10'h110;
	// self-test control field positions
	localparam int rbl_bit_start = 10;
	localparam int rbl_bit_pass = 9;
	localparam int rbl_bit_fail = 8;
	localparam int rbl_bit_analog = 5;
	localparam int rbl_bit_sync = 4;
	localparam int rbl_bit_bus = 3;
	// reset values and ram geometry
	localparam logic [15:0] rbl_ctrl_reset = 16'h0000;
	localparam logic [12:0] rbl_half_offset = 13'h1000;
	localparam logic [11:0] rbl_quad_last = 12'h7FF;
	localparam logic [11:0] rbl_half_last = 12'hFFF;
	// interrupt status bit positions
	localparam int rbl_irq_pass = 0;
	localparam int rbl_irq_fail = 1;
	// bist walk states
	typedef enum logic [2:0] {
		rbl_idle = 3'b001,
		rbl_run = 3'b010,
		rbl_done = 3'b100
	} rbl_state_type;
endpackage

// ---- design/rbl_top.sv ----
// Implementation choice: register access over Avalon-MM.
`timescale 1ns/10ps
`default_nettype none
// How it works
// - clean bist completion sets pass flag; writing start one clears it.
// - bist error sets fail flag; writing start one clears it.
// - on failure the hint register holds the lowest-quadrant address tested.
// - halves tested in parallel; fault is at hint, or hint plus 0x800, 0x1000 or 0x1800.
// - with test pin low the hint location reads message information word.
// - control bits seven and six ignore writes and read zero.
// - analog select low gives digital loopback, nothing driven on bus.
// - analog select high sends and receives test word on external bus.
// - sync select high gives command sync, low gives data sync.
// - start bit sets only with test pin high; self-clears at completion.
// - bus select low picks first bus, high picks second.
module rbl_top (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// avalon-mm slave
	input wire logic [9:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// test pin and message word from the terminal core
	input wire logic test_pin,
	input wire logic [15:0] msg_info_word,
	// loopback steering toward the transceivers
	output logic loopback_digital,
	output logic loopback_analog_tx,
	output logic loopback_bus_b,
	output logic loopback_command_sync,
	// interrupt
	output logic irq
);
	import rbl_pkg::*;

	typedef struct packed {
		logic [1:0] test_sync;
		logic [15:0] ctrl;
		logic [11:0] hint;
		logic [15:0] fault;
		logic [1:0] int_status;
		logic [1:0] int_enable;
		logic [31:0] rdata;
		logic ack;
		logic start;
		logic lb_dig;
		logic lb_ana;
		logic lb_bus;
		logic lb_cmd;
		logic irq;
	} rbl_top_type;

	rbl_top_type r;
	rbl_top_type next_r;
	rbl_bist_if bist();

	rbl_bist_engine u_engine (
		.clk(clk),
		.reset(reset),
		.bist(bist)
	);

	// byte-lane merge of a 16-bit register
	function automatic logic [15:0] merge(input logic [15:0] old,
		input logic [31:0] d, input logic [3:0] be);
		merge[7:0] = be[0] ? d[7:0] : old[7:0];
		merge[15:8] = be[1] ? d[15:8] : old[15:8];
	endfunction

	logic test_hi;
	logic wr;
	logic rd;
	logic [15:0] wctrl;
	assign test_hi = r.test_sync[1];
	// a write lands at the edge where the master sees waitrequest low
	assign wr = avs_write && r.ack;
	assign rd = avs_read && !r.ack;
	assign wctrl = merge(r.ctrl, avs_writedata, avs_byteenable);

	////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		next_r = r;
		next_r.test_sync = {r.test_sync[0], test_pin};
		next_r.ack = (avs_read || avs_write) && !r.ack;
		next_r.start = 1'b0;
		// completion: exactly one result flag per run
		if (bist.done) begin
			next_r.ctrl[rbl_bit_start] = 1'b0;
			next_r.ctrl[rbl_bit_pass] = !bist.failed;
			next_r.ctrl[rbl_bit_fail] = bist.failed;
			if (bist.failed) begin
				next_r.hint = bist.hint;
			end
			// sticky: a new result never clears the other bit
			next_r.int_status[rbl_irq_pass] = r.int_status[rbl_irq_pass]
				| !bist.failed;
			next_r.int_status[rbl_irq_fail] = r.int_status[rbl_irq_fail]
				| bist.failed;
		end
		// register writes
		if (wr) begin
			if (avs_address == rbl_addr_ctrl) begin
				next_r.ctrl[5:3] = wctrl[5:3];
				next_r.ctrl[7:6] = 2'b00;
				if (wctrl[rbl_bit_start] && test_hi
					&& !r.ctrl[rbl_bit_start]) begin
					next_r.ctrl[rbl_bit_start] = 1'b1;
					next_r.ctrl[rbl_bit_pass] = 1'b0;
					next_r.ctrl[rbl_bit_fail] = 1'b0;
					next_r.start = 1'b1;
				end
			end
			if (avs_address == rbl_addr_int_enable) begin
				next_r.int_enable = avs_writedata[1:0];
			end
			if (avs_address == rbl_addr_int_clear) begin
				// a same-cycle completion keeps its bit
				next_r.int_status = (r.int_status & ~avs_writedata[1:0])
					| (bist.done ? {bist.failed, !bist.failed} : 2'b00);
			end
			if (avs_address == rbl_addr_fault_inject) begin
				next_r.fault = merge(r.fault, avs_writedata, avs_byteenable);
			end
		end
		// read mux
		next_r.rdata = 32'h0000_0000;
		if (rd) begin
			unique case (avs_address)
				rbl_addr_ctrl: next_r.rdata = {16'h0000, r.ctrl};
				rbl_addr_hint: begin
					if (test_hi) begin
						next_r.rdata = {20'h00000, r.hint};
					end else begin
						next_r.rdata = {16'h0000, msg_info_word};
					end
				end
				rbl_addr_int_status: next_r.rdata = {30'h0, r.int_status};
				rbl_addr_int_enable: next_r.rdata = {30'h0, r.int_enable};
				rbl_addr_fault_inject: next_r.rdata = {16'h0000, r.fault};
				default: next_r.rdata = 32'h0000_0000;
			endcase
		end
		// loopback steering: digital and analog only while the test pin is high; bus and sync always follow
		next_r.lb_dig = test_hi && !r.ctrl[rbl_bit_analog];
		next_r.lb_ana = test_hi && r.ctrl[rbl_bit_analog];
		next_r.lb_bus = r.ctrl[rbl_bit_bus];
		next_r.lb_cmd = r.ctrl[rbl_bit_sync];
		next_r.irq = |(r.int_status & r.int_enable);
	end

	////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge clk) begin
		if (reset) begin
			r <= '{test_sync: 2'b00, ctrl: rbl_ctrl_reset, hint: 12'h000,
				fault: 16'h0000, int_status: 2'b00, int_enable: 2'b00,
				rdata: 32'h0000_0000, ack: 1'b0, start: 1'b0,
				lb_dig: 1'b0, lb_ana: 1'b0, lb_bus: 1'b0, lb_cmd: 1'b0,
				irq: 1'b0};
		end else begin
			r <= next_r;
		end
	end

	// outputs straight from flip-flops
	assign bist.start = r.start;
	assign bist.fault_addr = r.fault;
	assign avs_readdata = r.rdata;
	assign avs_waitrequest = !r.ack;
	assign loopback_digital = r.lb_dig;
	assign loopback_analog_tx = r.lb_ana;
	assign loopback_bus_b = r.lb_bus;
	assign loopback_command_sync = r.lb_cmd;
	assign irq = r.irq;
endmodule
`default_nettype wire

// ---- tb/rbl_top_asserts.sv ----
`timescale 1ns/10ps
`default_nettype none
// port-level checks of bus timing and self-test fields
module rbl_top_asserts (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// bus
	input wire logic [9:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	// pins
	input wire logic test_pin,
	input wire logic [15:0] msg_info_word,
	input wire logic loopback_digital,
	input wire logic loopback_analog_tx,
	input wire logic loopback_bus_b,
	input wire logic loopback_command_sync
);
	import rbl_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// accepted read and accepted control write
	wire rd_ack = avs_read && !avs_waitrequest;
	wire wr_ctrl = avs_write && !avs_waitrequest
		&& avs_address == rbl_addr_ctrl;
	////////////////////////////////////////////////////////////////////////
	chk_wait_answer: assert property ($rose(avs_read || avs_write)
		|=> !avs_waitrequest)
		else $error("no answer one cycle after request");
	chk_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low too long");
	chk_lb_exclusive: assert property (
		!(loopback_digital && loopback_analog_tx))
		else $error("digital and analog loopback together");
	chk_lb_gated: assert property (!test_pin [*4]
		|=> !loopback_digital && !loopback_analog_tx)
		else $error("loopback active with test pin low");
	chk_unused_zero: assert property (
		rd_ack && avs_address == rbl_addr_ctrl |-> avs_readdata[7:6] == 2'h0)
		else $error("unused control bits not zero");
	chk_one_result: assert property (
		rd_ack && avs_address == rbl_addr_ctrl
		|-> !(avs_readdata[9] && avs_readdata[8]))
		else $error("pass and fail both set");
	chk_hint_msg: assert property (
		rd_ack && avs_address == rbl_addr_hint && !test_pin
		&& !$past(test_pin, 4)
		|-> avs_readdata[15:0] == $past(msg_info_word))
		else $error("hint location not message word");
	chk_bus_follow: assert property (
		wr_ctrl |-> ##2 loopback_bus_b == $past(avs_writedata[3], 2))
		else $error("bus select not followed");
	chk_sync_follow: assert property (
		wr_ctrl |-> ##2 loopback_command_sync == $past(avs_writedata[4], 2))
		else $error("sync select not followed");
endmodule
bind rbl_top rbl_top_asserts i_rbl_top_asserts (.clk, .reset, .avs_address,
	.avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
	.test_pin, .msg_info_word, .loopback_digital, .loopback_analog_tx,
	.loopback_bus_b, .loopback_command_sync);
`default_nettype wire

// ---- tb/test_rbl_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module test_rbl_top;
	import rbl_pkg::*;
	logic clk = 0, reset = 1, avs_read = 0, avs_write = 0, test_pin = 0;
	logic [9:0] avs_address = 0;
	logic [31:0] avs_writedata = 0, avs_readdata, rd;
	logic [3:0] avs_byteenable = 4'h3;
	logic [15:0] msg_info_word = 0;
	logic avs_waitrequest, loopback_digital, loopback_analog_tx, irq;
	logic loopback_bus_b, loopback_command_sync;
	logic [11:0] x;
	int failures = 0, check_count = 0, seed = 5;
	rbl_top i_rbl_top (.clk, .reset, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
		.test_pin, .msg_info_word, .loopback_digital, .loopback_analog_tx,
		.loopback_bus_b, .loopback_command_sync, .irq);
	////////////////////////////////////////////////////////////////////////
	function automatic int xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// one avalon access, held until waitrequest is sampled low
	// no cycle limit here: only the watchdog ends a hung wait
	task automatic bus(input logic wr, input logic [9:0] a,
		input logic [31:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !wr;
		avs_write <= wr;
		do begin
			@(posedge clk);
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 0;
		avs_write <= 0;
		@(posedge clk);
	endtask
	// one self-test run, polled until the start bit drops
	task automatic bist(input logic [15:0] fi);
		int n;
		n = 0;
		bus(1, rbl_addr_fault_inject, {16'h0, fi});
		bus(1, rbl_addr_ctrl, 32'h0400);
		bus(0, rbl_addr_ctrl, 0);
		check(rd[10:8], 3'h4);
		do begin
			bus(0, rbl_addr_ctrl, 0);
			n++;
		end while (rd[10] && n < 3000);
	endtask
	task automatic test_done();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	// clock and watchdog
	initial forever #4 clk = ~clk;
	initial begin
		repeat (60000) @(posedge clk);
		failures++;
		test_done();
	end
	// main sequence
	initial begin
		repeat (8) @(posedge clk);
		reset <= 0;
		msg_info_word <= 16'(xs());
		bus(1, rbl_addr_ctrl, 32'h04F8);
		bus(0, rbl_addr_ctrl, 0);
		check(rd[10], 0);
		bus(0, rbl_addr_hint, 0);
		check(rd, {16'h0, msg_info_word});
		bus(0, 10'h3FC, 0);
		check(rd, 0);
		test_pin <= 1;
		repeat (3) @(posedge clk);
		for (int i = 0; i < 8; i++) begin
			bus(1, rbl_addr_ctrl, 32'hC0 | (i << 3));
			bus(0, rbl_addr_ctrl, 0);
			check(rd, i << 3);
			// bit 5 analog, bit 4 sync, bit 3 bus
			check({loopback_digital, loopback_analog_tx, loopback_bus_b,
				loopback_command_sync},
				{!i[2], i[2], i[0], i[1]});
		end
		bus(1, rbl_addr_int_enable, 3);
		bist(0);
		check(rd[10:8], 3'h2);
		check(irq, 1);
		bus(1, rbl_addr_int_clear, 3);
		bus(1, rbl_addr_int_enable, 0);
		x = 12'(xs());
		bist({4'h9, x});
		check(rd[10:8], 3'h1);
		check(irq, 0);
		bus(0, rbl_addr_int_status, 0);
		check(rd, 2);
		bus(0, rbl_addr_hint, 0);
		check(rd, {21'h0, x[10:0]});
		bus(1, rbl_addr_int_enable, 3);
		repeat (2) @(posedge clk);
		check(irq, 1);
		test_pin <= 0;
		repeat (5) @(posedge clk);
		check({loopback_digital, loopback_analog_tx}, 0);
		bus(0, rbl_addr_hint, 0);
		check(rd, {16'h0, msg_info_word});
		test_done();
	end
endmodule
`default_nettype wire
